/* File: csma_ifs_pkg.sv */
package csma_ifs_pkg;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SYMBOL_PERIOD_NS = 16000;
    localparam int SYMBOL_CYCLES =
        (SYMBOL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0] SYMBOL_LAST = 9'(SYMBOL_CYCLES - 1);
    localparam int BACKOFF_UNIT_SYMBOLS = 20;
    localparam logic [4:0] BACKOFF_LAST = 5'(BACKOFF_UNIT_SYMBOLS - 1);
    localparam logic [6:0] MAX_SIFS_OCTETS = 7'h12;
    localparam logic [2:0] MAX_BE = 3'h5;
    localparam logic [2:0] BLE_MAX_BE = 3'h2;
    localparam logic [1:0] CW_SLOTTED = 2'h2;
    localparam logic [1:0] CW_UNSLOTTED = 2'h1;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // ==========================================================
    // register map
    localparam int ADDR_W = 10;
    localparam int NUM_REGS = 31;
    typedef logic [ADDR_W-1:0] addr_t;
    localparam addr_t REG_OFFSET [NUM_REGS] = '{
        10'h000, 10'h010, 10'h011, 10'h013, 10'h01E, 10'h01F, 10'h020,
        10'h021, 10'h022, 10'h023, 10'h025, 10'h026, 10'h027, 10'h02E,
        10'h035, 10'h224, 10'h225, 10'h226, 10'h227, 10'h228, 10'h229,
        10'h230, 10'h231, 10'h232, 10'h233, 10'h234, 10'h235, 10'h236,
        10'h237, 10'h238, 10'h239};
    // reserved bits are not stored and read as zero
    localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
        8'h2F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
        8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'h08, 8'hF0, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h83,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] REG_RESET [NUM_REGS] = '{
        8'h00, 8'h00, 8'h1C, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h84, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h75,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00};
    localparam int IDX_TX_MAC_CONTROL = 2;
    localparam int IDX_TX_PENDING_CONTROL = 7;
    localparam int IDX_TURNAROUND_REGISTER = 12;
    localparam int IDX_TX_SETTLE_REGISTER = 13;
    localparam addr_t REG_CSMA_STATUS = 10'h03F;

    // ==========================================================
    // field positions
    localparam int BYPASS_BIT = 7;
    localparam int BLE_BIT = 6;
    localparam int SLOTTED_BIT = 5;
    localparam int MINBE_LSB = 3;
    localparam int MAXBO_LSB = 0;
    localparam int SHORT_BASE_LSB = 0;
    localparam int SETTLE_LSB = 4;
    localparam int LONG_BASE_LSB = 2;
    localparam int TURN_BASE_LSB = 4;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_TURN     = 3'b001,
        ST_GAP      = 3'b010,
        ST_BACKOFF  = 3'b011,
        ST_CCA      = 3'b100,
        ST_CCA_WAIT = 3'b101,
        ST_ON_AIR   = 3'b110,
        ST_ACK_WAIT = 3'b111
    } state_t;
    typedef enum logic [1:0] {
        KIND_DATA   = 2'b00,
        KIND_ACK    = 2'b01,
        KIND_BEACON = 2'b10
    } kind_t;
endpackage

/* File: csma_ifs_timing.sv */
`timescale 1ns/1ps
module csma_ifs_timing
    import csma_ifs_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // register port
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    input  wire logic [7:0]        i_reg_wdata,
    output logic      [7:0]        o_reg_rdata,
    // transmit request
    input  wire logic              i_tx_req,
    input  wire logic [1:0]        i_tx_kind,
    input  wire logic [6:0]        i_tx_len,
    input  wire logic              i_tx_ack_req,
    input  wire logic              i_tx_after_datareq,
    output logic                   o_busy,
    // superframe
    input  wire logic              i_in_cap,
    input  wire logic              i_slot_boundary,
    // channel assessment
    output logic                   o_cca_req,
    input  wire logic              i_cca_done,
    input  wire logic              i_cca_clear,
    // radio
    output logic                   o_tx_go,
    input  wire logic              i_tx_done,
    input  wire logic              i_ack_done,
    output logic                   o_access_fail
);

    // ==========================================================
    // register file
    logic [7:0]          regs_ff [NUM_REGS];
    logic [7:0]          nxt_regs [NUM_REGS];
    logic [NUM_REGS-1:0] hit;
    logic [7:0]          rdata_ff;
    logic [7:0]          nxt_rdata;
    logic [7:0]          rd_val;
    state_t              state_ff;
    state_t              nxt_state;
    logic [2:0]          nb_ff;
    logic [2:0]          nxt_nb;
    logic [1:0]          cw_ff;
    logic [1:0]          nxt_cw;

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            assign hit[g] = (i_reg_addr == REG_OFFSET[g]);
            always_comb begin
                nxt_regs[g] = regs_ff[g];
                if (i_reg_wr && hit[g]) begin
                    nxt_regs[g] = i_reg_wdata & REG_WMASK[g];
                end
            end
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    regs_ff[g] <= REG_RESET[g];
                end else begin
                    regs_ff[g] <= nxt_regs[g];
                end
            end
        end
    endgenerate

    // unmapped addresses read as zero
    always_comb begin
        rd_val = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_val = regs_ff[i];
            end
        end
        if (i_reg_addr == REG_CSMA_STATUS) begin
            rd_val = {state_ff, nb_ff, cw_ff};
        end
        nxt_rdata = i_reg_rd ? rd_val : rdata_ff;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_reg_rdata = rdata_ff;

    // ==========================================================
    // configuration fields
    logic       cfg_bypass;
    logic       cfg_ble;
    logic       cfg_slotted;
    logic [1:0] cfg_minbe;
    logic [2:0] cfg_maxbo;
    logic [3:0] short_base;
    logic [3:0] settle;
    logic [5:0] long_base;
    logic [3:0] turn_base;
    logic [6:0] short_gap;
    logic [6:0] long_gap;
    logic [6:0] turn_time;

    assign cfg_bypass  = regs_ff[IDX_TX_MAC_CONTROL][BYPASS_BIT];
    assign cfg_ble     = regs_ff[IDX_TX_MAC_CONTROL][BLE_BIT];
    assign cfg_slotted = regs_ff[IDX_TX_MAC_CONTROL][SLOTTED_BIT];
    assign cfg_minbe   = regs_ff[IDX_TX_MAC_CONTROL][MINBE_LSB +: 2];
    assign cfg_maxbo   = regs_ff[IDX_TX_MAC_CONTROL][MAXBO_LSB +: 3];
    assign short_base  = regs_ff[IDX_TX_SETTLE_REGISTER][SHORT_BASE_LSB +: 4];
    assign settle      = regs_ff[IDX_TX_SETTLE_REGISTER][SETTLE_LSB +: 4];
    assign long_base   = regs_ff[IDX_TX_PENDING_CONTROL][LONG_BASE_LSB +: 6];
    assign turn_base   = regs_ff[IDX_TURNAROUND_REGISTER][TURN_BASE_LSB +: 4];
    assign short_gap   = {3'h0, short_base} + {3'h0, settle};
    assign long_gap    = {1'h0, long_base} + {3'h0, settle};
    assign turn_time   = {3'h0, turn_base} + {3'h0, settle};

    // ==========================================================
    // symbol and backoff timebase
    logic [8:0] sym_cnt_ff;
    logic [8:0] nxt_sym_cnt;
    logic [4:0] bo_cnt_ff;
    logic [4:0] nxt_bo_cnt;
    logic       sym_tick;
    logic       bo_tick;

    assign sym_tick = (sym_cnt_ff == SYMBOL_LAST);
    // free-running, so unslotted backoffs relate to no other node
    assign bo_tick  = sym_tick && (bo_cnt_ff == BACKOFF_LAST);

    always_comb begin
        nxt_sym_cnt = sym_tick ? 9'h000 : sym_cnt_ff + 9'h001;
        nxt_bo_cnt  = bo_cnt_ff;
        if (sym_tick) begin
            nxt_bo_cnt = bo_tick ? 5'h00 : bo_cnt_ff + 5'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sym_cnt_ff <= 9'h000;
            bo_cnt_ff  <= 5'h00;
        end else begin
            sym_cnt_ff <= nxt_sym_cnt;
            bo_cnt_ff  <= nxt_bo_cnt;
        end
    end

    // ==========================================================
    // random source for backoff draws
    logic [15:0] lfsr_ff;
    logic [15:0] nxt_lfsr;

    always_comb begin
        nxt_lfsr = {lfsr_ff[14:0],
                    lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lfsr_ff <= LFSR_SEED;
        end else begin
            lfsr_ff <= nxt_lfsr;
        end
    end

    // ==========================================================
    // access sequencer
    logic [2:0] be_ff;
    logic [2:0] nxt_be;
    logic [4:0] bo_left_ff;
    logic [4:0] nxt_bo_left;
    logic [6:0] gap_ff;
    logic [6:0] nxt_gap;
    logic       slotted_ff;
    logic       nxt_slotted;
    logic       csma_ff;
    logic       nxt_csma;
    logic       ack_req_ff;
    logic       nxt_ack_req;
    logic       long_ff;
    logic       nxt_long;
    logic       go_ff;
    logic       nxt_go;
    logic       fail_ff;
    logic       nxt_fail;
    logic       unit_tick;
    logic [2:0] be_first;
    logic [2:0] be_up;
    logic [6:0] gap_after;

    // slotted backoffs count only coordinator slot boundaries
    assign unit_tick = slotted_ff ? i_slot_boundary : bo_tick;
    assign be_first  = (slotted_ff && cfg_ble && cfg_minbe > 2'(BLE_MAX_BE)) ?
                       BLE_MAX_BE : {1'h0, cfg_minbe};
    assign be_up     = (be_ff >= MAX_BE) ? MAX_BE : be_ff + 3'h1;
    // one extra symbol covers the partial first symbol
    assign gap_after = (long_ff ? long_gap : short_gap) + 7'h01;

    function automatic logic [4:0] draw(input logic [2:0] be, input logic [4:0] rnd);
        logic [5:0] span;
        span = (6'h01 << be) - 6'h01;
        return rnd & span[4:0];
    endfunction

    always_comb begin
        nxt_state   = state_ff;
        nxt_be      = be_ff;
        nxt_nb      = nb_ff;
        nxt_cw      = cw_ff;
        nxt_bo_left = bo_left_ff;
        nxt_gap     = gap_ff;
        nxt_slotted = slotted_ff;
        nxt_csma    = csma_ff;
        nxt_ack_req = ack_req_ff;
        nxt_long    = long_ff;
        nxt_go      = 1'b0;
        nxt_fail    = 1'b0;
        if (sym_tick && gap_ff != 7'h00) begin
            nxt_gap = gap_ff - 7'h01;
        end
        case (state_ff)
            ST_IDLE: begin
                if (i_tx_req) begin
                    nxt_ack_req = i_tx_ack_req && (i_tx_kind == KIND_DATA);
                    nxt_long    = i_tx_len > MAX_SIFS_OCTETS;
                    nxt_slotted = cfg_slotted;
                    nxt_csma    = (i_tx_kind == KIND_DATA) && !cfg_bypass &&
                                  !(cfg_slotted && (!i_in_cap || i_tx_after_datareq));
                    if (i_tx_kind == KIND_ACK) begin
                        nxt_gap   = turn_time + 7'h01;
                        nxt_state = ST_TURN;
                    end else if (i_tx_kind == KIND_BEACON) begin
                        nxt_go    = 1'b1;
                        nxt_state = ST_ON_AIR;
                    end else begin
                        nxt_state = ST_GAP;
                    end
                end
            end
            ST_TURN: begin
                if (gap_ff == 7'h00) begin
                    nxt_go    = 1'b1;
                    nxt_state = ST_ON_AIR;
                end
            end
            ST_GAP: begin
                if (gap_ff == 7'h00) begin
                    if (csma_ff) begin
                        nxt_nb      = 3'h0;
                        nxt_cw      = slotted_ff ? CW_SLOTTED : CW_UNSLOTTED;
                        nxt_be      = be_first;
                        nxt_bo_left = draw(be_first, lfsr_ff[4:0]);
                        nxt_state   = ST_BACKOFF;
                    end else begin
                        nxt_go    = 1'b1;
                        nxt_state = ST_ON_AIR;
                    end
                end
            end
            ST_BACKOFF: begin
                if (unit_tick) begin
                    if (bo_left_ff == 5'h00) begin
                        nxt_state = ST_CCA;
                    end else begin
                        nxt_bo_left = bo_left_ff - 5'h01;
                    end
                end
            end
            ST_CCA: begin
                nxt_state = ST_CCA_WAIT;
            end
            ST_CCA_WAIT: begin
                if (i_cca_done) begin
                    if (i_cca_clear) begin
                        if (cw_ff == 2'h1) begin
                            nxt_go    = 1'b1;
                            nxt_state = ST_ON_AIR;
                        end else begin
                            // second assessment on the next boundary
                            nxt_cw      = cw_ff - 2'h1;
                            nxt_bo_left = 5'h00;
                            nxt_state   = ST_BACKOFF;
                        end
                    end else if (nb_ff >= cfg_maxbo) begin
                        nxt_fail  = 1'b1;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_nb      = nb_ff + 3'h1;
                        nxt_be      = be_up;
                        nxt_cw      = slotted_ff ? CW_SLOTTED : CW_UNSLOTTED;
                        nxt_bo_left = draw(be_up, lfsr_ff[4:0]);
                        nxt_state   = ST_BACKOFF;
                    end
                end
            end
            ST_ON_AIR: begin
                if (i_tx_done) begin
                    if (ack_req_ff) begin
                        nxt_state = ST_ACK_WAIT;
                    end else begin
                        nxt_gap   = gap_after;
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_ACK_WAIT: begin
                if (i_ack_done) begin
                    nxt_gap   = gap_after;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff   <= ST_IDLE;
            be_ff      <= 3'h0;
            nb_ff      <= 3'h0;
            cw_ff      <= 2'h0;
            bo_left_ff <= 5'h00;
            gap_ff     <= 7'h00;
            slotted_ff <= 1'b0;
            csma_ff    <= 1'b0;
            ack_req_ff <= 1'b0;
            long_ff    <= 1'b0;
            go_ff      <= 1'b0;
            fail_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            be_ff      <= nxt_be;
            nb_ff      <= nxt_nb;
            cw_ff      <= nxt_cw;
            bo_left_ff <= nxt_bo_left;
            gap_ff     <= nxt_gap;
            slotted_ff <= nxt_slotted;
            csma_ff    <= nxt_csma;
            ack_req_ff <= nxt_ack_req;
            long_ff    <= nxt_long;
            go_ff      <= nxt_go;
            fail_ff    <= nxt_fail;
        end
    end

    assign o_busy        = (state_ff != ST_IDLE);
    assign o_cca_req     = (state_ff == ST_CCA);
    assign o_tx_go       = go_ff;
    assign o_access_fail = fail_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_take_req;
        state_ff == ST_IDLE && i_tx_req;
    endsequence
    sequence s_csma_start;
        state_ff == ST_GAP && gap_ff == 7'h00 && csma_ff;
    endsequence
    sequence s_frame_end;
        state_ff == ST_ON_AIR && i_tx_done;
    endsequence

    AST_CCA_AFTER_BACKOFF:
        assert property (o_cca_req |-> $past(state_ff) == ST_BACKOFF)
        else $error("cca without a finished backoff");
    AST_SLOTTED_ALIGN:
        assert property ((slotted_ff && state_ff == ST_BACKOFF) ##1 state_ff == ST_CCA
                         |-> $past(i_slot_boundary))
        else $error("slotted cca off a slot boundary");
    AST_UNSLOTTED_OWN_UNIT:
        assert property ((!slotted_ff && state_ff == ST_BACKOFF) ##1 state_ff == ST_CCA
                         |-> $past(bo_tick))
        else $error("unslotted cca off own backoff unit");
    AST_MODE_SELECT:
        assert property (s_take_req |=> slotted_ff == $past(cfg_slotted))
        else $error("access mode not taken from control bit");
    AST_BLE_EXPONENT:
        assert property (s_csma_start ##0 (slotted_ff && cfg_ble) |=> be_ff <= BLE_MAX_BE)
        else $error("battery life extension exponent too large");
    AST_MIN_EXPONENT:
        assert property (s_csma_start ##0 !(slotted_ff && cfg_ble)
                         |=> be_ff == {1'h0, $past(cfg_minbe)})
        else $error("first exponent differs from minimum");
    AST_FAIL_AT_MAX:
        assert property (o_access_fail |-> $past(nb_ff) >= $past(cfg_maxbo)
                         && state_ff == ST_IDLE)
        else $error("access failure before backoff limit");
    AST_SHORT_GAP:
        assert property (s_frame_end ##0 (!ack_req_ff && !long_ff)
                         |=> gap_ff == $past(short_gap) + 7'h01)
        else $error("short gap wrong");
    AST_LONG_GAP:
        assert property (s_frame_end ##0 (!ack_req_ff && long_ff)
                         |=> gap_ff == $past(long_gap) + 7'h01)
        else $error("long gap wrong");
    AST_GAP_AFTER_ACK:
        assert property (s_frame_end ##0 ack_req_ff
                         |=> state_ff == ST_ACK_WAIT && gap_ff == 7'h00)
        else $error("gap started before acknowledgment");
    AST_TURNAROUND:
        assert property (s_take_req ##0 (i_tx_kind == KIND_ACK)
                         |=> state_ff == ST_TURN && gap_ff == $past(turn_time) + 7'h01)
        else $error("turnaround not loaded");
    AST_DATAREQ_DIRECT:
        assert property (s_take_req ##0 (cfg_slotted && i_tx_after_datareq)
                         |=> !csma_ff)
        else $error("data-request reply went through csma");
    AST_BEACON_DIRECT:
        assert property (s_take_req ##0 (i_tx_kind == KIND_BEACON) |=> o_tx_go)
        else $error("beacon not sent directly");
endmodule

/* File: far_radio.sv */
`timescale 1ns/1ps
// ==========================================================
// other radios on the channel: answer assessments, end frames
module far_radio (
    // clock
    input  wire logic        i_clk,
    // from the block, plus the bench's acknowledgment request
    input  wire logic        i_cca_req,
    input  wire logic        i_tx_go,
    input  wire logic        i_want_ack,
    // scenario controls
    input  wire logic        i_free,
    input  wire logic [15:0] i_lat,
    // to the block
    output logic             o_cca_done,
    output logic             o_cca_clear,
    output logic             o_tx_done,
    output logic             o_ack_done
);
    initial begin
        o_cca_done = 0;
        o_cca_clear = 0;
        o_tx_done = 0;
        o_ack_done = 0;
    end
    // result line shows the inverse outside its valid cycle
    always begin
        @(posedge i_clk iff i_cca_req);
        repeat (i_lat) @(negedge i_clk);
        o_cca_clear = i_free;
        o_cca_done = 1;
        @(negedge i_clk);
        o_cca_done = 0;
        o_cca_clear = ~i_free;
    end
    always begin
        @(posedge i_clk iff i_tx_go);
        repeat (i_lat) @(negedge i_clk);
        o_tx_done = 1;
        @(negedge i_clk);
        o_tx_done = 0;
        if (i_want_ack) begin
            repeat (i_lat) @(negedge i_clk);
            o_ack_done = 1;
            @(negedge i_clk);
            o_ack_done = 0;
        end
    end
endmodule

/* File: csma_ca_ifs_timing_tb.sv */
`timescale 1ns/1ps
module csma_ca_ifs_timing_tb;
    import csma_ifs_pkg::*;
    // ==========================================================
    // signals
    logic        clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, req = 0, ack = 0;
    logic        in_cap = 0, sb = 0, free = 1, slot_chk = 0, dreq = 0;
    logic        busy, cca_req, cca_done, cca_clr, tx_go, tx_done, ack_done, fail;
    logic [9:0]  addr = '0;
    logic [7:0]  wdata = '0, rdata;
    logic [1:0]  kind = '0;
    logic [6:0]  len = '0;
    logic [15:0] lat = 16'h0014;
    int          err_total = 0, comparisons = 0, ncca = 0, sbcnt = 0, cycles = 0, age = 0;

    always #20 clk = ~clk;

    csma_ifs_timing DUT (.i_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr_s),
        .i_reg_rd(rd_s), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_tx_req(req),
        .i_tx_kind(kind), .i_tx_len(len), .i_tx_ack_req(ack), .i_tx_after_datareq(dreq),
        .o_busy(busy), .i_in_cap(in_cap), .i_slot_boundary(sb), .o_cca_req(cca_req),
        .i_cca_done(cca_done), .i_cca_clear(cca_clr), .o_tx_go(tx_go),
        .i_tx_done(tx_done), .i_ack_done(ack_done), .o_access_fail(fail));
    far_radio partner (.i_clk(clk), .i_cca_req(cca_req), .i_tx_go(tx_go), .i_want_ack(ack),
        .i_free(free), .i_lat(lat), .o_cca_done(cca_done), .o_cca_clear(cca_clr),
        .o_tx_done(tx_done), .o_ack_done(ack_done));

    // ==========================================================
    // helpers
    task automatic chk(input logic [15:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk); addr = a; wdata = d; wr_s = 1;
        @(negedge clk); wr_s = 0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge clk); addr = a; rd_s = 1;
        @(negedge clk); rd_s = 0;
        @(negedge clk); d = rdata;
    endtask
    task automatic send(input logic [1:0] k, input logic [6:0] n, input logic a,
                        output int c, output logic f);
        @(negedge clk); kind = k; len = n; ack = a; req = 1; ncca = 0; c = 0;
        @(negedge clk); req = 0;
        while (!tx_go && !fail && c < 60000) begin @(negedge clk); c++; end
        f = fail;
        while (busy) @(negedge clk);
    endtask

    // boundaries every backoff unit of 20 symbols; age counts cycles since one
    always @(negedge clk) begin
        sb <= (sbcnt == 7999);
        sbcnt <= (sbcnt == 7999) ? 0 : sbcnt + 1;
    end
    always @(posedge clk) begin
        cycles++;
        age = sb ? 0 : age + 1;
        if (cca_req) begin
            ncca++;
            if (slot_chk) chk(16'(age <= 2), 16'h0001, "cca off boundary");
        end
        if (cycles == 100000) begin err_total++; give_verdict(); end
    end

    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [7:0] d;
        rd(10'h011, d); chk(16'(d), 16'h001C, "txmac reset");
        rd(10'h02E, d); chk(16'(d), 16'h0075, "settle reset");
        rd(10'h021, d); chk(16'(d), 16'h0084, "pending reset");
        rd(10'h027, d); chk(16'(d), 16'h0050, "turn reset");
        rd(10'h03F, d); chk(16'(d), 16'h0000, "status idle");
        wr(10'h3FF, 8'hFF);
        rd(10'h3FF, d); chk(16'(d), 16'h0000, "unmapped read");
        wr(10'h011, 8'h00);
        rd(10'h011, d); chk(16'(d), 16'h0000, "txmac write");
        wr(10'h02E, 8'h11);
        wr(10'h021, 8'h28);
        wr(10'h027, 8'h10);
    endtask
    task automatic t_direct();
        int c; logic f;
        send(KIND_BEACON, 7'h0A, 1'b0, c, f); chk(16'(c), 16'h0000, "beacon");
        chk(16'(ncca), 16'h0000, "beacon cca");
        send(KIND_ACK, 7'h05, 1'b0, c, f);
        chk(16'(c >= 800 && c <= 1202), 16'h0001, "turnaround");
        chk(16'(ncca), 16'h0000, "ack cca");
    endtask
    task automatic t_fail();
        int c; logic f;
        free = 0;
        send(KIND_DATA, 7'h0A, 1'b0, c, f); chk(16'(f), 16'h0001, "no fail");
        chk(16'(ncca), 16'h0001, "cca count max 0");
        wr(10'h011, 8'h01);
        send(KIND_DATA, 7'h0A, 1'b0, c, f); chk(16'(f), 16'h0001, "no fail");
        chk(16'(ncca), 16'h0002, "cca count max 1");
        free = 1;
    endtask
    task automatic t_gaps();
        int c; logic f;
        lat = 16'h0258;
        // bypass, so tx_go marks the end of the gap alone; gaps are 2 and 11 symbols
        wr(10'h011, 8'h80);
        send(KIND_DATA, 7'h12, 1'b1, c, f); chk(16'(f), 16'h0000, "refused");
        send(KIND_DATA, 7'h13, 1'b0, c, f);
        chk(16'(c >= 798 && c <= 1200), 16'h0001, "short gap");
        send(KIND_DATA, 7'h05, 1'b0, c, f);
        chk(16'(c >= 4398 && c <= 4800), 16'h0001, "long gap");
        chk(16'(ncca), 16'h0000, "bypass cca");
        lat = 16'h0014;
    endtask
    task automatic t_slotted();
        int c; logic f;
        // minimum exponent 3, but battery life extension caps the first backoff exponent at 2
        wr(10'h011, 8'h79);
        in_cap = 1;
        slot_chk = 1;
        send(KIND_DATA, 7'h05, 1'b0, c, f); chk(16'(f), 16'h0000, "slotted fail");
        chk(16'(ncca), 16'h0002, "two assessments");
        chk(16'(c <= 41300), 16'h0001, "ble backoff span");
        slot_chk = 0;
        dreq = 1;
        send(KIND_DATA, 7'h05, 1'b0, c, f);
        chk(16'(ncca), 16'h0000, "data-request reply cca");
        dreq = 0;
        in_cap = 0;
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1;
        t_regs();
        t_direct();
        t_fail();
        t_gaps();
        t_slotted();
        give_verdict();
    end
endmodule
